// [verilog/spg_pkg.sv]
package spg_pkg;
  // core clock
  localparam int          CLK_PERIOD_NS   = 4;
  localparam int          CLK_HZ_DEF      = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int          KEY_TIMEOUT_S   = 15;
  localparam int          LINE_HZ_60      = 60;
  localparam int          LINE_HZ_50      = 50;
  // rate selector positions and rates in tenths of a baud
  localparam logic [3:0]  SEL_50          = 4'h1;
  localparam logic [3:0]  SEL_75          = 4'h2;
  localparam logic [3:0]  SEL_110         = 4'h3;
  localparam logic [3:0]  SEL_134         = 4'h4;
  localparam logic [3:0]  SEL_150         = 4'h5;
  localparam logic [3:0]  SEL_300         = 4'h6;
  localparam logic [3:0]  SEL_600         = 4'h7;
  localparam logic [3:0]  SEL_1200        = 4'h8;
  localparam logic [3:0]  SEL_19200       = 4'hf;
  localparam int          BAUD10_50       = 500;
  localparam int          BAUD10_75       = 750;
  localparam int          BAUD10_110      = 1100;
  localparam int          BAUD10_134      = 1345;
  localparam int          BAUD10_150      = 1500;
  localparam int          BAUD10_300      = 3000;
  localparam int          BAUD10_600      = 6000;
  localparam int          BAUD10_1200     = 12000;
  localparam int          BAUD10_19200    = 192000;
  // reset values of the captured configuration, and the load count at which the straps are captured
  localparam logic [7:0]  ADDR_RST        = 8'h31;
  localparam logic [23:0] DIV_RST         = 24'h032dcd;
  localparam logic [1:0]  LOAD_AT         = 2'h2;
  // frame shape
  localparam logic [3:0]  BITS_ONE_STOP   = 4'hb;
  localparam logic [3:0]  BITS_TWO_STOP   = 4'hc;
  localparam int          CMD_CTRL_BIT    = 7;
  // register offsets
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_CONFIG      = 8'h04;
  localparam logic [7:0]  OFS_STATUS      = 8'h08;
  localparam int          CTRL_RELOAD     = 0;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_PAR   = 5'b01000,
    RX_STOP  = 5'b10000
  } spg_rx_e;

  typedef enum logic [3:0] {
    MS_ADDR = 4'b0001,
    MS_CMD  = 4'b0010,
    MS_EXEC = 4'b0100,
    MS_SEND = 4'b1000
  } spg_msg_e;
endpackage

// [verilog/spg_serial_port.sv]
`timescale 1ns/1ps
// Behaviour
// - straps captured only after reset or program reload, never while running
// - vertical sync period for 60 Hz when line strap fitted, else 50 Hz
// - peripheral address built from low and high hex digit selectors, 00 to FF
// - default peripheral address is hex 31
// - receive and transmit rates come from separate selectors
// - selector positions map to 50 through 19200 baud
// - both rates default to 1200 baud
// - even parity with strap fitted, odd without; generated and checked
// - one stop bit with strap fitted, two without
// - output drive strap fitted: line always driven, marking when idle
// - drive strap removed: driver enabled only while sending
// - local mode ignores remote switching commands
// - local mode serves status unless keypad active or confirm in progress
// - remote mode switches on link commands, keypad commands dropped
// - local or remote tag shown from keyswitch state
// - accepted command is executed then a status byte is sent back
// - video power has no effect on control or serial logic
// - keypad active until 15 s pass without a key press in local mode
// - transmit on transmit line, receive on receive line
module spg_serial_port #(
  parameter int     CLK_HZ          = spg_pkg::CLK_HZ_DEF,
  parameter longint KEY_TIMEOUT_CYC = longint'(CLK_HZ) * spg_pkg::KEY_TIMEOUT_S
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        lineFreqStrap,
  input  wire logic [3:0]  addrLowDigitSel,
  input  wire logic [3:0]  addrHighDigitSel,
  input  wire logic [3:0]  rxRateSel,
  input  wire logic [3:0]  txRateSel,
  input  wire logic        parityStrap,
  input  wire logic        stopBitStrap,
  input  wire logic        outputDriveStrap,
  input  wire logic        modeRemoteSw,
  input  wire logic        rxData,
  output logic             txData,
  output logic             txDataOe,
  input  wire logic        keyPress,
  input  wire logic        keyCmdValid,
  output logic             keyCmdAccept,
  input  wire logic        confirmBusy,
  output logic             matrixCmdValid,
  output logic [6:0]       matrixCmd,
  input  wire logic        matrixDone,
  input  wire logic [7:0]  statusByte,
  output logic             localModeTag,
  output logic             remoteModeTag,
  output logic             vsyncPulse,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdData
);

  ////////////////////////////////////////////////////////////////////////////
  // rate selector to bit period in cycles
  function automatic logic [23:0] rateDiv(input logic [3:0] sel);
    int baud10;
    baud10 = spg_pkg::BAUD10_1200;
    unique case (sel)
      spg_pkg::SEL_50:    baud10 = spg_pkg::BAUD10_50;
      spg_pkg::SEL_75:    baud10 = spg_pkg::BAUD10_75;
      spg_pkg::SEL_110:   baud10 = spg_pkg::BAUD10_110;
      spg_pkg::SEL_134:   baud10 = spg_pkg::BAUD10_134;
      spg_pkg::SEL_150:   baud10 = spg_pkg::BAUD10_150;
      spg_pkg::SEL_300:   baud10 = spg_pkg::BAUD10_300;
      spg_pkg::SEL_600:   baud10 = spg_pkg::BAUD10_600;
      spg_pkg::SEL_19200: baud10 = spg_pkg::BAUD10_19200;
      default:            baud10 = spg_pkg::BAUD10_1200;
    endcase
    rateDiv = 24'((longint'(CLK_HZ) * 64'd10) / longint'(baud10));
  endfunction

  localparam logic [23:0] VS_60 = 24'(CLK_HZ / spg_pkg::LINE_HZ_60);
  localparam logic [23:0] VS_50 = 24'(CLK_HZ / spg_pkg::LINE_HZ_50);
  localparam logic [31:0] KEY_T = 32'(KEY_TIMEOUT_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int SW = 22;
  logic [SW-1:0] pinRaw;
  logic [SW-1:0] pinMeta_r;
  logic [SW-1:0] pinSync_r;
  assign pinRaw = {lineFreqStrap, addrLowDigitSel, addrHighDigitSel, rxRateSel, txRateSel,
                   parityStrap, stopBitStrap, outputDriveStrap, modeRemoteSw, rxData};
  always_ff @(posedge ref_clk) begin
    pinMeta_r <= pinRaw;
    pinSync_r <= pinMeta_r;
  end
  logic rxS;
  logic modeSwS;
  assign rxS     = pinSync_r[0];
  assign modeSwS = pinSync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // strap capture
  logic [1:0]  loadCnt_r;
  logic        lineFreq60_r;
  logic [7:0]  periphAddr_r;
  logic [23:0] rxDiv_r;
  logic [23:0] txDiv_r;
  logic        parityEven_r;
  logic        stopOne_r;
  logic        driveAlways_r;
  logic        reloadReq;
  assign reloadReq = regWr && regAddr == spg_pkg::OFS_CTRL && regWrData[spg_pkg::CTRL_RELOAD];

  always_ff @(posedge ref_clk) begin
    if (!rst_n || reloadReq) begin
      loadCnt_r <= '0;
    end else if (loadCnt_r <= spg_pkg::LOAD_AT) begin
      loadCnt_r <= loadCnt_r + 2'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lineFreq60_r  <= 1'b1;
      periphAddr_r  <= spg_pkg::ADDR_RST;
      rxDiv_r       <= spg_pkg::DIV_RST;
      txDiv_r       <= spg_pkg::DIV_RST;
      parityEven_r  <= 1'b1;
      stopOne_r     <= 1'b1;
      driveAlways_r <= 1'b1;
    end else if (loadCnt_r == spg_pkg::LOAD_AT) begin
      lineFreq60_r  <= pinSync_r[21];
      periphAddr_r  <= {pinSync_r[16:13], pinSync_r[20:17]};
      rxDiv_r       <= rateDiv(pinSync_r[12:9]);
      txDiv_r       <= rateDiv(pinSync_r[8:5]);
      parityEven_r  <= pinSync_r[4];
      stopOne_r     <= pinSync_r[3];
      driveAlways_r <= pinSync_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  spg_pkg::spg_rx_e rxState_r;
  logic [23:0]      rxCnt_r;
  logic [2:0]       rxIdx_r;
  logic [7:0]       rxShift_r;
  logic             rxPar_r;
  logic             rxValid_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rxState_r <= spg_pkg::RX_IDLE;
      rxCnt_r   <= '0;
      rxIdx_r   <= '0;
      rxShift_r <= '0;
      rxPar_r   <= 1'b0;
      rxValid_r <= 1'b0;
    end else begin
      rxValid_r <= 1'b0;
      if (rxState_r == spg_pkg::RX_IDLE) begin
        if (!rxS) begin
          rxState_r <= spg_pkg::RX_START;
          rxCnt_r   <= rxDiv_r >> 1;
        end
      end else if (rxCnt_r != '0) begin
        rxCnt_r <= rxCnt_r - 24'd1;
      end else begin
        rxCnt_r <= rxDiv_r - 24'd1;
        unique case (rxState_r)
          spg_pkg::RX_START: begin
            rxState_r <= rxS ? spg_pkg::RX_IDLE : spg_pkg::RX_DATA;
            rxIdx_r   <= '0;
          end
          spg_pkg::RX_DATA: begin
            rxShift_r <= {rxS, rxShift_r[7:1]};
            rxIdx_r   <= rxIdx_r + 3'd1;
            if (rxIdx_r == 3'd7) begin
              rxState_r <= spg_pkg::RX_PAR;
            end
          end
          spg_pkg::RX_PAR: begin
            rxPar_r   <= rxS;
            rxState_r <= spg_pkg::RX_STOP;
          end
          default: begin
            rxValid_r <= rxS && ((^{rxShift_r, rxPar_r}) != parityEven_r);
            rxState_r <= spg_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // keypad activity and mode
  logic [31:0] keyTimer_r;
  logic        keypadActive;
  logic        remote_r;
  spg_pkg::spg_msg_e msState_r;
  logic        txBusy;
  assign keypadActive = keyTimer_r != '0;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      keyTimer_r <= '0;
    end else if (keyPress && !remote_r) begin
      keyTimer_r <= KEY_T;
    end else if (keypadActive) begin
      keyTimer_r <= keyTimer_r - 32'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      remote_r      <= 1'b0;
      localModeTag  <= 1'b0;
      remoteModeTag <= 1'b0;
      keyCmdAccept  <= 1'b0;
    end else begin
      if (msState_r == spg_pkg::MS_ADDR && !txBusy && rxState_r == spg_pkg::RX_IDLE) begin
        remote_r <= modeSwS;
      end
      localModeTag  <= !remote_r;
      remoteModeTag <= remote_r;
      keyCmdAccept  <= keyCmdValid && !remote_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // message handling
  logic txGo;
  logic cmdIsCtrl;
  logic cmdOk;
  assign txGo      = msState_r == spg_pkg::MS_SEND && !txBusy;
  assign cmdIsCtrl = rxShift_r[spg_pkg::CMD_CTRL_BIT];
  assign cmdOk     = remote_r || (!cmdIsCtrl && !keypadActive && !confirmBusy);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      msState_r      <= spg_pkg::MS_ADDR;
      matrixCmdValid <= 1'b0;
      matrixCmd      <= '0;
    end else begin
      matrixCmdValid <= 1'b0;
      unique case (msState_r)
        spg_pkg::MS_ADDR: begin
          if (rxValid_r && rxShift_r == periphAddr_r) begin
            msState_r <= spg_pkg::MS_CMD;
          end
        end
        spg_pkg::MS_CMD: begin
          if (rxValid_r) begin
            if (!cmdOk) begin
              msState_r <= spg_pkg::MS_ADDR;
            end else if (cmdIsCtrl) begin
              matrixCmdValid <= 1'b1;
              matrixCmd      <= rxShift_r[6:0];
              msState_r      <= spg_pkg::MS_EXEC;
            end else begin
              msState_r <= spg_pkg::MS_SEND;
            end
          end
        end
        spg_pkg::MS_EXEC: begin
          if (matrixDone) begin
            msState_r <= spg_pkg::MS_SEND;
          end
        end
        spg_pkg::MS_SEND: begin
          if (txGo) begin
            msState_r <= spg_pkg::MS_ADDR;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter
  logic [11:0] txShift_r;
  logic [3:0]  txLeft_r;
  logic [23:0] txCnt_r;
  assign txBusy = txLeft_r != '0;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      txShift_r <= '1;
      txLeft_r  <= '0;
      txCnt_r   <= '0;
    end else if (txGo) begin
      txShift_r <= {2'b11, (^statusByte) ^ !parityEven_r, statusByte, 1'b0};
      txLeft_r  <= stopOne_r ? spg_pkg::BITS_ONE_STOP : spg_pkg::BITS_TWO_STOP;
      txCnt_r   <= txDiv_r - 24'd1;
    end else if (txBusy) begin
      if (txCnt_r == '0) begin
        txShift_r <= {1'b1, txShift_r[11:1]};
        txLeft_r  <= txLeft_r - 4'd1;
        txCnt_r   <= txDiv_r - 24'd1;
      end else begin
        txCnt_r <= txCnt_r - 24'd1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      txData   <= 1'b1;
      txDataOe <= 1'b0;
    end else begin
      txData   <= txBusy ? txShift_r[0] : 1'b1;
      txDataOe <= driveAlways_r || txBusy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vertical sync timing, independent of video power
  logic [23:0] vsCnt_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vsCnt_r    <= '0;
      vsyncPulse <= 1'b0;
    end else begin
      vsyncPulse <= vsCnt_r == '0;
      vsCnt_r    <= (vsCnt_r == '0) ? (lineFreq60_r ? VS_60 : VS_50) - 24'd1 : vsCnt_r - 24'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      regRdData <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        spg_pkg::OFS_CONFIG: regRdData <= {12'h000, driveAlways_r, stopOne_r, parityEven_r,
                                           lineFreq60_r, 8'h00, periphAddr_r};
        spg_pkg::OFS_STATUS: regRdData <= {24'h000000, msState_r, rxState_r != spg_pkg::RX_IDLE,
                                           txBusy, keypadActive, remote_r};
        default:             regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

endmodule

// [sim/spg_serial_port_chk.sv]
`timescale 1ns/1ps
module spg_serial_port_chk (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        txData,
  input wire logic        txDataOe,
  input wire logic        keyCmdValid,
  input wire logic        keyCmdAccept,
  input wire logic        matrixCmdValid,
  input wire logic [6:0]  matrixCmd,
  input wire logic        localModeTag,
  input wire logic        remoteModeTag,
  input wire logic        vsyncPulse,
  input wire logic        regRd,
  input wire logic [31:0] regRdData
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // start bit with the driver on
  sequence s_start;
    $fell(txData) ##0 txDataOe;
  endsequence
  AST_VSYNC_GAP: assert property (vsyncPulse |=> !vsyncPulse [*8])
    else $error("vsync pulse repeats too soon");
  AST_TAG_EXCL: assert property (localModeTag |-> !remoteModeTag)
    else $error("both mode tags shown");
  AST_KEY_TAKE: assert property (keyCmdValid && localModeTag |=> keyCmdAccept)
    else $error("keypad command not taken in local");
  AST_KEY_DROP: assert property (keyCmdValid && remoteModeTag |=> !keyCmdAccept)
    else $error("keypad command taken in remote");
  AST_KEY_CAUSE: assert property (keyCmdAccept |-> $past(keyCmdValid))
    else $error("keypad accept without command");
  AST_IDLE_MARK: assert property (!txDataOe |-> txData)
    else $error("line not marking while released");
  AST_START_BIT: assert property (s_start |=> !txData [*8])
    else $error("start bit too short");
  AST_CMD_PULSE: assert property (matrixCmdValid |=> !matrixCmdValid)
    else $error("matrix command pulse too long");
  AST_CMD_REMOTE: assert property (matrixCmdValid |-> remoteModeTag)
    else $error("switching in local mode");
  AST_CMD_HOLD: assert property (!matrixCmdValid |-> $stable(matrixCmd))
    else $error("matrix command changed without pulse");
  AST_RD_CAUSE: assert property (regRdData != 32'h0 |-> $past(regRd))
    else $error("read data without read");
endmodule
bind spg_serial_port spg_serial_port_chk u_spg_serial_port_chk (.ref_clk, .rst_n, .txData, .txDataOe, .keyCmdValid,
  .keyCmdAccept, .matrixCmdValid, .matrixCmd, .localModeTag, .remoteModeTag, .vsyncPulse, .regRd, .regRdData);

// [sim/spg_remote_model.sv]
`timescale 1ns/1ps
module spg_remote_model (
  input wire logic        ref_clk,
  input wire logic        txData,
  input wire logic        txDataOe,
  input wire logic        evenPar,
  input wire logic        twoStop,
  input wire logic [15:0] sendDiv,
  input wire logic [15:0] recvDiv,
  output logic            rxData
);
  logic [7:0] gotByte;
  logic [8:0] sh;
  logic       parOk;
  logic       lineLvl;
  int         gotCnt = 0;
  initial rxData = 1'b1;
  // released line reads as marking
  assign lineLvl = txDataOe ? txData : 1'b1;
  // lsb first, parity, one or two stops
  task automatic send_byte(input logic [7:0] b);
    logic [11:0] f;
    f = {2'b11, ^b ^ ~evenPar, b, 1'b0};
    for (int i = 0; i < (twoStop ? 12 : 11); i++) begin
      rxData <= f[i];
      repeat (sendDiv) @(posedge ref_clk);
    end
  endtask
  // capture reply at mid-bit, check parity and stop
  initial forever begin
    @(negedge lineLvl);
    repeat (recvDiv / 2) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      repeat (recvDiv) @(posedge ref_clk);
      if (i < 9) sh[i] = lineLvl;
      else parOk = lineLvl && ((^sh) != evenPar);
    end
    gotByte = sh[7:0];
    gotCnt++;
  end
endmodule

// [sim/spg_serial_port_tb.sv]
`timescale 1ns/1ps
module spg_serial_port_tb;
  localparam int HZ = 200_000;
  localparam int D1200 = HZ * 10 / spg_pkg::BAUD10_1200;
  logic        ref_clk, rst_n = 1'b0, rxData, txData, txDataOe, keyCmdAccept, matrixCmdValid;
  logic        lineFreqStrap = 1'b1, parityStrap = 1'b1, stopBitStrap = 1'b1, outputDriveStrap = 1'b1;
  logic        modeRemoteSw = 1'b0, keyPress = 1'b0, keyCmdValid = 1'b0, confirmBusy = 1'b0;
  logic        matrixDone = 1'b0, regWr = 1'b0, regRd = 1'b0, localModeTag, remoteModeTag, vsyncPulse;
  logic        evenPar = 1'b1, twoStop = 1'b0;
  logic [3:0]  addrLowDigitSel = 4'h1, addrHighDigitSel = 4'h3, rxRateSel = 4'h8, txRateSel = 4'h8;
  logic [6:0]  matrixCmd;
  logic [7:0]  statusByte = 8'ha5, regAddr = 8'h00;
  logic [15:0] sendDiv = 16'(D1200), recvDiv = 16'(D1200);
  logic [31:0] regWrData = 32'h0, regRdData, rd;
  int          n_fail = 0, total_checks = 0, nCmd = 0, per;
  spg_serial_port #(.CLK_HZ(HZ), .KEY_TIMEOUT_CYC(200)) u_spg_serial_port (.ref_clk, .rst_n, .lineFreqStrap,
    .addrLowDigitSel, .addrHighDigitSel, .rxRateSel, .txRateSel, .parityStrap, .stopBitStrap, .outputDriveStrap,
    .modeRemoteSw, .rxData, .txData, .txDataOe, .keyPress, .keyCmdValid, .keyCmdAccept, .confirmBusy,
    .matrixCmdValid, .matrixCmd, .matrixDone, .statusByte, .localModeTag, .remoteModeTag, .vsyncPulse,
    .regAddr, .regWrData, .regWr, .regRd, .regRdData);
  spg_remote_model u_spg_remote_model (.ref_clk, .txData, .txDataOe, .evenPar, .twoStop, .sendDiv, .recvDiv,
    .rxData);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (matrixCmdValid === 1'b1) nCmd <= nCmd + 1;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk("register", exp, regRdData);
  endtask
  task automatic msg(input logic [7:0] a, input logic [7:0] c, input int quiet);
    @(posedge ref_clk);
    u_spg_remote_model.send_byte(a);
    u_spg_remote_model.send_byte(c);
    repeat (quiet) @(posedge ref_clk);
  endtask
  task automatic chk_resp(input int n);
    for (int i = 0; i < 30000 && u_spg_remote_model.gotCnt == n; i++) @(posedge ref_clk);
    chk("replies", n + 1, u_spg_remote_model.gotCnt);
    chk("reply", 32'ha5, u_spg_remote_model.gotByte);
    chk("parity", 32'h1, u_spg_remote_model.parOk);
  endtask
  task automatic vsync_period(input int exp);
    per = 0;
    @(posedge ref_clk iff vsyncPulse === 1'b1);
    do begin
      @(posedge ref_clk);
      per++;
    end while (vsyncPulse !== 1'b1 && per < 9000);
    chk("vsync period", exp, per);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    reg_rd(spg_pkg::OFS_CONFIG, 32'h000f0031);
    reg_rd(8'h0c, 32'h0);
    chk("local tag", 32'h1, localModeTag);
    vsync_period(HZ / spg_pkg::LINE_HZ_60);
    @(posedge ref_clk);
    keyPress <= 1'b1;
    keyCmdValid <= 1'b1;
    @(posedge ref_clk);
    keyPress <= 1'b0;
    keyCmdValid <= 1'b0;
    #1 chk("key accept", 32'h1, keyCmdAccept);
    reg_rd(spg_pkg::OFS_STATUS, 32'h12);
    repeat (250) @(posedge ref_clk);
    reg_rd(spg_pkg::OFS_STATUS, 32'h10);
    msg(8'h31, 8'h85, 14 * D1200);
    chk("local switching", 32'h0, nCmd + u_spg_remote_model.gotCnt);
    confirmBusy <= 1'b1;
    msg(8'h31, 8'h00, 14 * D1200);
    chk("busy reply", 32'h0, u_spg_remote_model.gotCnt);
    confirmBusy <= 1'b0;
    msg(8'h31, 8'h00, 0);
    chk_resp(0);
    modeRemoteSw <= 1'b1;
    repeat (D1200) @(posedge ref_clk);
    chk("remote tag", 32'h1, remoteModeTag);
    keyCmdValid <= 1'b1;
    @(posedge ref_clk);
    keyCmdValid <= 1'b0;
    #1 chk("key drop", 32'h0, keyCmdAccept);
    msg(8'h31, 8'h85, 0);
    chk("command", 32'h085, {nCmd[24:0], matrixCmd});
    chk("early reply", 32'h1, u_spg_remote_model.gotCnt);
    matrixDone <= 1'b1;
    @(posedge ref_clk);
    matrixDone <= 1'b0;
    chk_resp(1);
    msg(8'h32, 8'h00, 14 * D1200);
    chk("foreign", 32'h2, u_spg_remote_model.gotCnt);
    {addrHighDigitSel, addrLowDigitSel, parityStrap, stopBitStrap} <= 10'h168;
    {outputDriveStrap, lineFreqStrap, rxRateSel, txRateSel} <= {2'b00, spg_pkg::SEL_19200, spg_pkg::SEL_600};
    reg_rd(spg_pkg::OFS_CONFIG, 32'h000f0031);
    reg_wr(spg_pkg::OFS_CTRL, 32'h1);
    repeat (4) @(posedge ref_clk);
    reg_rd(spg_pkg::OFS_CONFIG, 32'h0000005a);
    evenPar <= 1'b0;
    twoStop <= 1'b1;
    sendDiv <= 16'(HZ * 10 / spg_pkg::BAUD10_19200);
    recvDiv <= 16'(HZ * 10 / spg_pkg::BAUD10_600);
    vsync_period(HZ / spg_pkg::LINE_HZ_50);
    chk("party idle", 32'h0, txDataOe);
    msg(8'h5a, 8'h00, 0);
    chk_resp(2);
    repeat (3 * HZ * 10 / spg_pkg::BAUD10_600) @(posedge ref_clk);
    chk("party release", 32'h0, txDataOe);
    end_of_test();
  end
endmodule
